// file: core/qixrp_link.sv
// four-line serial read path with continuous reads, wrap setup and a byte store
// assumes the host owns the serial clock; enable bits are slow levels
`default_nettype none
`timescale 1ns/1ps

// How it works
// (R01) sample on rising edge, drive on falling
// (R02) opcode serial on line 0 only
// (R03) address takes six four-bit clocks
// (R04) writes capture address and data, four bits
// (R05) reads turn lines to outputs after address
// (R06) host always drives the mode byte
// (R07) dummy clocks between address and data
// (R08) continuous mode needs both enable bits
// (R09) continuous mode only for the two reads
// (R10) aligned read clears low address bits
// (R11) mode bits 5:4 equal 10 enter mode
// (R12) in mode, frames start with address
// (R13) deselect stops driving, mode survives
// (R14) other mode bits leave after the access
// (R15) in mode only the read executes
// (R16) wrap setup limits reads to sections
// (R17) wrap byte bits 6:4 pick length
// (R18) host leaves mode before new wrap setup
// (R19) wrap setup uses four-line format
// (R20) other mode bits are ignored
module qixrp_link #(
    parameter int DUMMY_CYCLES = qixrp_pkg::DUMMY_CLKS, // read turnaround clocks
    parameter int MEM_AW = 8                            // byte store address bits
) (
    input wire logic SYS_CLK,                 // system clock
    input wire logic RSTN,                    // asynchronous reset, active low
    input wire logic SCK,                     // serial clock from the host
    input wire logic CS_N,                    // chip select, active low
    input wire logic [3:0] IO_IN,             // levels on the four data lines
    output logic [3:0] IO_OUT,                // data driven onto the lines
    output logic [3:0] IO_OE,                 // high while a line is driven
    input wire logic QUAD_ENABLE_BIT,         // quad enable status bit
    input wire logic CONT_READ_ENABLE,        // continuous read enable status bit
    output logic CONTINUOUS_READ_MODE         // mode state, system side
);

    // refuse values the counters cannot serve
    if (DUMMY_CYCLES < 1 || DUMMY_CYCLES > 255) begin : g_chk_dummy
        $error("qixrp_link: DUMMY_CYCLES must be 1..255");
    end
    if (MEM_AW < 1 || MEM_AW > 16) begin : g_chk_aw
        $error("qixrp_link: MEM_AW must be 1..16");
    end

    ////////////////////////////////////////////////////////////////////////////////
    // declarations

    localparam logic [7:0] CMD_LAST = 8'(qixrp_pkg::CMD_BITS - 1);   // last opcode clock
    localparam logic [7:0] ADDR_LAST = 8'(qixrp_pkg::ADDR_CLKS - 1);  // last address clock
    localparam logic [7:0] MODE_LAST = 8'(qixrp_pkg::MODE_CLKS - 1);  // last mode clock
    localparam logic [7:0] WRAP_LAST = 8'(qixrp_pkg::WRAP_CLKS - 1);  // last wrap clock
    localparam logic [7:0] DUMMY_LAST = 8'(DUMMY_CYCLES - 1);        // last dummy clock

    qixrp_pkg::qixrp_frame_t f;        // frame state
    qixrp_pkg::qixrp_frame_t next_f;   // frame state, next
    qixrp_pkg::qixrp_keep_t k;         // kept state
    qixrp_pkg::qixrp_keep_t next_k;    // kept state, next
    qixrp_pkg::qixrp_drive_t d;        // line drivers
    qixrp_pkg::qixrp_drive_t next_d;   // line drivers, next

    logic frame_rst_n;       // low outside a frame or under reset
    logic [1:0] en_sync;     // enable bits in the serial domain
    logic modes_ok;          // both enable bits set
    logic [7:0] cmd_shift;   // opcode including this clock's bit
    logic [23:0] addr_shift; // address including this clock's nibble
    logic [7:0] byte_in;     // held nibble joined with this clock's
    logic mem_we;            // store write strobe
    logic [7:0] mem_rdata;   // store read data

    ////////////////////////////////////////////////////////////////////////////////
    // crossings

    // select high clears the frame logic
    assign frame_rst_n = RSTN & ~CS_N;

    // enable bits into the serial domain
    qixrp_sync #(
        .WIDTH(2)
    ) u_en_sync (
        .clk(SCK),
        .rst_n(RSTN),
        .din({CONT_READ_ENABLE, QUAD_ENABLE_BIT}),
        .dout(en_sync)
    );

    // mode state back to the system side
    qixrp_sync #(
        .WIDTH(1)
    ) u_mode_sync (
        .clk(SYS_CLK),
        .rst_n(RSTN),
        .din(k.crm),
        .dout(CONTINUOUS_READ_MODE)
    );

    assign modes_ok = en_sync[0] & en_sync[1]; // R08

    ////////////////////////////////////////////////////////////////////////////////
    // byte store

    qixrp_mem #(
        .AW(MEM_AW),
        .DW(8)
    ) u_mem (
        .clk(SCK),
        .we(mem_we),
        .waddr(f.addr[MEM_AW-1:0]),
        .wdata(byte_in),
        .raddr(next_f.addr[MEM_AW-1:0]),
        .rdata(mem_rdata)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // next read address, wrapping when set up

    function automatic logic [23:0] step_addr(input logic [23:0] a, input logic en,
                                              input logic [1:0] sel);
        logic [23:0] mask;
        mask = (qixrp_pkg::WRAP_BASE << sel) - 24'h00_0001;
        if (en) begin
            step_addr = (a & ~mask) | ((a + 24'h00_0001) & mask); // R16
        end else begin
            step_addr = a + 24'h00_0001;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // frame sequencer, rising edge sampling

    always_comb begin
        next_f = f;
        next_k = k;
        mem_we = 1'b0;
        cmd_shift = {f.cmd[6:0], IO_IN[0]}; // R02
        addr_shift = {f.addr[19:0], IO_IN}; // R03
        byte_in = {f.nib, IO_IN};
        case (f.state)
            qixrp_pkg::ST_START: begin
                if (k.crm && modes_ok) begin
                    // commandless frame: reuse the read opcode
                    next_f.cmd = k.op; // R12 R15
                    next_f.addr = addr_shift; // R12
                    next_f.cnt = 8'h01;
                    next_f.state = qixrp_pkg::ST_ADDR;
                end else begin
                    // opcode frame: first bit on line 0
                    next_f.cmd = cmd_shift; // R02
                    next_f.cnt = 8'h01;
                    next_f.state = qixrp_pkg::ST_CMD;
                end
            end
            qixrp_pkg::ST_CMD: begin
                next_f.cmd = cmd_shift; // R02
                next_f.cnt = f.cnt + 8'h01;
                if (f.cnt == CMD_LAST) begin
                    next_f.cnt = 8'h00;
                    if (!en_sync[0]) begin
                        // four-line formats need quad enable
                        next_f.state = qixrp_pkg::ST_IGNORE;
                    end else if (cmd_shift == qixrp_pkg::OP_READ_ANY ||
                                 cmd_shift == qixrp_pkg::OP_READ_ALIGNED ||
                                 cmd_shift == qixrp_pkg::OP_QUAD_WRITE) begin
                        next_f.state = qixrp_pkg::ST_ADDR; // R09
                    end else if (cmd_shift == qixrp_pkg::OP_WRAP_SET) begin
                        next_f.state = qixrp_pkg::ST_WRAP; // R19
                    end else begin
                        // unknown opcode
                        next_f.state = qixrp_pkg::ST_IGNORE;
                    end
                end
            end
            qixrp_pkg::ST_ADDR: begin
                next_f.addr = addr_shift; // R03 R04
                next_f.cnt = f.cnt + 8'h01;
                if (f.cnt == ADDR_LAST) begin
                    next_f.cnt = 8'h00;
                    next_f.phase = 1'b0;
                    if (f.cmd == qixrp_pkg::OP_READ_ALIGNED) begin
                        next_f.addr[qixrp_pkg::ALIGN_BITS-1:0] = '0; // R10
                    end
                    if (f.cmd == qixrp_pkg::OP_QUAD_WRITE) begin
                        next_f.state = qixrp_pkg::ST_WDATA; // R04
                    end else begin
                        next_f.state = qixrp_pkg::ST_MODE;
                    end
                end
            end
            qixrp_pkg::ST_MODE: begin
                next_f.cnt = f.cnt + 8'h01;
                if (f.cnt != MODE_LAST) begin
                    // upper mode nibble holds bits 7:4
                    next_f.nib = IO_IN;
                end else begin
                    // only bits 5:4 count; acts from next select
                    next_k.crm = modes_ok && (f.nib[1:0] == qixrp_pkg::MODE_STAY_CODE); // R11 R14 R20 R08
                    next_k.op = f.cmd; // R09
                    next_f.cnt = 8'h00;
                    next_f.state = qixrp_pkg::ST_DUMMY;
                end
            end
            qixrp_pkg::ST_DUMMY: begin
                next_f.cnt = f.cnt + 8'h01;
                if (f.cnt == DUMMY_LAST) begin
                    // first byte read at this edge
                    next_f.cnt = 8'h00;
                    next_f.phase = 1'b0;
                    next_f.state = qixrp_pkg::ST_RDATA; // R07
                end
            end
            qixrp_pkg::ST_RDATA: begin
                // address steps after the lower nibble
                next_f.phase = ~f.phase; // R05
                if (f.phase) begin
                    next_f.addr = step_addr(f.addr, k.wrap_en, k.wrap_sel); // R16
                end
            end
            qixrp_pkg::ST_WDATA: begin
                next_f.phase = ~f.phase;
                if (!f.phase) begin
                    next_f.nib = IO_IN; // R04
                end else begin
                    // byte in: store it
                    mem_we = 1'b1; // R04
                    next_f.addr = f.addr + 24'h00_0001;
                end
            end
            qixrp_pkg::ST_WRAP: begin
                next_f.cnt = f.cnt + 8'h01;
                if (f.cnt != WRAP_LAST) begin
                    next_f.nib = IO_IN; // R19
                end else begin
                    next_k.wrap_en = ~byte_in[qixrp_pkg::WRAP_OFF_POS]; // R17
                    next_k.wrap_sel = byte_in[qixrp_pkg::WRAP_SEL_LSB +: 2]; // R17
                    next_f.state = qixrp_pkg::ST_IGNORE;
                end
            end
            qixrp_pkg::ST_IGNORE: begin
                // wait for deselect
                next_f.state = qixrp_pkg::ST_IGNORE;
            end
            default: begin
                next_f = qixrp_pkg::FRAME_RST;
            end
        endcase
    end

    // frame state, cleared by deselect
    always_ff @(posedge SCK or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            f <= qixrp_pkg::FRAME_RST; // R13
        end else begin
            f <= next_f; // R01
        end
    end

    // kept state, reset only, so the mode outlives deselect
    always_ff @(posedge SCK or negedge RSTN) begin
        if (!RSTN) begin
            k <= qixrp_pkg::KEEP_RST;
        end else begin
            k <= next_k; // R13
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // line drivers, falling edge

    // upper nibble first; inputs outside read data
    always_comb begin
        next_d = qixrp_pkg::DRIVE_RST;
        if (f.state == qixrp_pkg::ST_RDATA) begin
            next_d.oe = 4'hF; // R05
            next_d.dout = f.phase ? mem_rdata[3:0] : mem_rdata[7:4]; // R05
        end
    end

    // deselect releases the lines at once
    always_ff @(negedge SCK or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            d <= qixrp_pkg::DRIVE_RST; // R13
        end else begin
            d <= next_d; // R01
        end
    end

    assign IO_OUT = d.dout;
    assign IO_OE = d.oe;

endmodule

`default_nettype wire

// file: core/qixrp_mem.sv
// small byte store behind the serial read path
// assumes one clock; registered read data
`default_nettype none
`timescale 1ns/1ps

module qixrp_mem #(
    parameter int AW = 8,
    parameter int DW = 8
) (
    input wire logic clk,                 // serial clock
    input wire logic we,                  // write strobe
    input wire logic [AW-1:0] waddr,      // write address
    input wire logic [DW-1:0] wdata,      // write data
    input wire logic [AW-1:0] raddr,      // read address
    output logic [DW-1:0] rdata           // registered read data
);

    // refuse sizes the store cannot hold
    if (AW < 1 || AW > 16 || DW < 1) begin : g_chk
        $error("qixrp_mem: AW must be 1..16 and DW at least one");
    end

    logic [DW-1:0] ram [0:(1<<AW)-1]; // storage

    ////////////////////////////////////////////////////////////////////////////////
    // write and registered read in one edge; a read of the written address returns the old byte
    always_ff @(posedge clk) begin
        if (we) begin
            ram[waddr] <= wdata;
        end
        rdata <= ram[raddr];
    end

endmodule

`default_nettype wire

// file: core/qixrp_sync.sv
// two flip-flop level synchroniser
// assumes slow levels; async active-low reset
`default_nettype none
`timescale 1ns/1ps

module qixrp_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk,                 // destination clock
    input wire logic rst_n,               // asynchronous reset
    input wire logic [WIDTH-1:0] din,     // level from the other domain
    output logic [WIDTH-1:0] dout         // synchronised level
);

    // refuse a zero width
    if (WIDTH < 1) begin : g_chk
        $error("qixrp_sync: WIDTH must be at least one");
    end

    logic [WIDTH-1:0] meta; // first stage, read only by the second

    ////////////////////////////////////////////////////////////////////////////////
    // two stages
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta <= '0;
            dout <= '0;
        end else begin
            meta <= din;
            dout <= meta;
        end
    end

endmodule

`default_nettype wire

// file: inc/qixrp_pkg.sv
// constants, states and carriers of the four-line read path
// assumes a host serial clock and a slow system clock
`default_nettype none

package qixrp_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // opcodes
    localparam logic [7:0] OP_READ_ANY = 8'hEB;      // continuous read, any address
    localparam logic [7:0] OP_READ_ALIGNED = 8'hE7;  // continuous read, aligned address
    localparam logic [7:0] OP_WRAP_SET = 8'h77;      // burst wrap setup
    localparam logic [7:0] OP_QUAD_WRITE = 8'h38;    // four-line address and data write

    ////////////////////////////////////////////////////////////////////////////////
    // phase lengths in serial clocks
    localparam int CMD_BITS = 8;       // opcode bits on line 0
    localparam int ADDR_CLKS = 6;      // 24 address bits, four per clock
    localparam int MODE_CLKS = 2;      // mode byte, four bits per clock
    localparam int WRAP_CLKS = 2;      // wrap byte, four bits per clock
    localparam int DUMMY_CLKS = 4;     // default dummy clocks before read data
    localparam int ADDR_W = 24;        // address width

    ////////////////////////////////////////////////////////////////////////////////
    // field positions and codes
    localparam int ALIGN_BITS = 2;                   // low address bits cleared when aligned
    localparam logic [1:0] MODE_STAY_CODE = 2'b10;   // mode[5:4] value that keeps the mode
    localparam int WRAP_OFF_POS = 6;                 // wrap byte bit: one disables wrapping
    localparam int WRAP_SEL_LSB = 4;                 // wrap byte bits 5:4: 8/16/32/64 bytes
    localparam logic [ADDR_W-1:0] WRAP_BASE = 24'h00_0008; // smallest wrap section

    ////////////////////////////////////////////////////////////////////////////////
    // frame states, one-hot
    typedef enum logic [8:0] {
        ST_START = 9'h001,   // first clock after select
        ST_CMD = 9'h002,     // opcode bits
        ST_ADDR = 9'h004,    // address nibbles
        ST_MODE = 9'h008,    // mode byte
        ST_DUMMY = 9'h010,   // turnaround clocks
        ST_RDATA = 9'h020,   // device drives data
        ST_WDATA = 9'h040,   // host drives data
        ST_WRAP = 9'h080,    // wrap setup byte
        ST_IGNORE = 9'h100   // rest of frame unused
    } qixrp_state_t;

    // state cleared at each select
    typedef struct packed {
        qixrp_state_t state;          // frame phase
        logic [7:0] cnt;              // clocks within phase
        logic [7:0] cmd;              // opcode in use
        logic [ADDR_W-1:0] addr;      // byte address
        logic [3:0] nib;              // held upper nibble
        logic phase;                  // 0 upper nibble, 1 lower nibble
    } qixrp_frame_t;

    // state kept across selects
    typedef struct packed {
        logic crm;                    // continuous read mode active
        logic [7:0] op;               // read opcode reused without command
        logic wrap_en;                // wrapping on
        logic [1:0] wrap_sel;         // wrap section size code
    } qixrp_keep_t;

    // line driver stage, falling edge
    typedef struct packed {
        logic [3:0] dout;             // data on the four lines
        logic [3:0] oe;               // high while driving
    } qixrp_drive_t;

    localparam qixrp_frame_t FRAME_RST = '{state: ST_START, cnt: 8'h00, cmd: 8'h00,
        addr: 24'h00_0000, nib: 4'h0, phase: 1'b0};
    localparam qixrp_keep_t KEEP_RST = '{crm: 1'b0, op: 8'h00, wrap_en: 1'b0,
        wrap_sel: 2'b00};
    localparam qixrp_drive_t DRIVE_RST = '{dout: 4'h0, oe: 4'h0};

endpackage

`default_nettype wire

// file: test/qixrp_host.sv
// host model, mode 0 timing
// assumes a device that drives on falling edges; clock idle low
`timescale 1ns/1ps
`default_nettype none

module qixrp_host (
    output logic sck, // serial clock
    output logic cs_n, // select, active low
    output logic [3:0] io_wire, // resolved line levels
    input wire logic [3:0] io_out, // device line data
    input wire logic [3:0] io_oe // device line enables
);
    logic [3:0] hval = 4'h0; // last value driven
    logic hdrv = 1'b0; // host drives the lines
    logic [3:0] smp; // nibble seen at a rise
    logic oe_seen = 1'b0; // device drove in this frame
    logic [7:0] rx; // byte read
    logic [3:0] tx_q[$]; // nibbles still to send
    event got; // a byte was read

    ////////////////////////////////////////////////////////////////////////////////
    // released lines show the inverse of the last drive
    assign io_wire = (io_oe & io_out) | (~io_oe & (hdrv ? hval : ~hval));

    initial begin
        sck = 1'b0;
        cs_n = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // change at fall, sample at rise
    task automatic clk1(input logic [3:0] v, input logic d);
        if (d) hval = v;
        hdrv = d;
        #62.5 sck = 1'b1;
        smp = io_wire;
        if (io_oe != 4'h0) oe_seen = 1'b1;
        #62.5 sck = 1'b0;
    endtask

    // frame: opcode, nibbles, dummy clocks, reads
    task automatic frame(input logic cmd, input logic [7:0] op, input int ndum, input int nrd);
        logic [7:0] b;
        oe_seen = 1'b0;
        cs_n = 1'b0;
        #40;
        if (cmd) begin
            // opcode on line 0, other lines carrying its inverse
            for (int i = 7; i >= 0; i--) clk1({{3{~op[i]}}, op[i]}, 1'b1);
        end
        // queued nibbles, always driven
        while (tx_q.size() > 0) clk1(tx_q.pop_front(), 1'b1);
        repeat (ndum) clk1(4'h0, 1'b0);
        for (int k = 0; k < nrd; k++) begin
            clk1(4'h0, 1'b0);
            b[7:4] = smp;
            clk1(4'h0, 1'b0);
            b[3:0] = smp;
            rx = b;
            -> got;
        end
        // deselect in mid-stream
        cs_n = 1'b1;
        #300;
    endtask
endmodule

`default_nettype wire

// file: test/qixrp_link_bench.sv
// bench of the four-line read path
// assumes the host model; bytes queued, compared on arrival
`timescale 1ns/1ps
`default_nettype none

module qixrp_link_bench;
    localparam int DUM = 4; // dummy clocks
    logic sys_clk = 1'b0; // system clock
    logic rstn = 1'b0; // reset, active low
    logic qe = 1'b0; // quad enable
    logic cre = 1'b0; // continuous read enable
    logic sck; // serial clock
    logic cs_n; // select
    logic [3:0] io_wire; // line levels
    logic [3:0] io_out; // device data
    logic [3:0] io_oe; // device enables
    logic crm; // mode state
    int miscompares = 0; // mismatches
    int tests_run = 0; // comparisons
    int wsz = 0; // wrap section bytes, 0 off
    logic [7:0] sop = 8'h00; // read opcode in use
    logic [7:0] mem [256]; // shadow of the store
    logic [7:0] exp_q[$]; // expected read bytes

    always #50 sys_clk = ~sys_clk;

    qixrp_link #(.DUMMY_CYCLES(DUM), .MEM_AW(8)) u_qixrp_link (
        .SYS_CLK(sys_clk), .RSTN(rstn), .SCK(sck), .CS_N(cs_n), .IO_IN(io_wire),
        .IO_OUT(io_out), .IO_OE(io_oe), .QUAD_ENABLE_BIT(qe), .CONT_READ_ENABLE(cre),
        .CONTINUOUS_READ_MODE(crm)
    );
    qixrp_host u_qixrp_host (.sck(sck), .cs_n(cs_n), .io_wire(io_wire), .io_out(io_out),
        .io_oe(io_oe));

    ////////////////////////////////////////////////////////////////////////////////
    // checks and builders
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp) begin
            $display("wrong value %s: expected %h, seen %h", what, exp, got);
            miscompares++;
        end
    endtask
    task automatic put8(input logic [7:0] v);
        u_qixrp_host.tx_q.push_back(v[7:4]);
        u_qixrp_host.tx_q.push_back(v[3:0]);
    endtask
    task automatic put24(input logic [23:0] a);
        for (int i = 5; i >= 0; i--) u_qixrp_host.tx_q.push_back(a[4*i+:4]);
    endtask
    // read frame; expected bytes aligned and wrapped
    task automatic rd(input logic cmd, input logic [7:0] op, input logic [23:0] a,
            input logic [7:0] m, input int n);
        logic [23:0] b, x;
        if (cmd) sop = op;
        b = (sop == qixrp_pkg::OP_READ_ALIGNED) ? {a[23:2], 2'b00} : a;
        for (int i = 0; i < n; i++) begin
            x = b + 24'(i);
            if (wsz > 0) x = (b & ~24'(wsz - 1)) | (x & 24'(wsz - 1));
            exp_q.push_back(mem[x[7:0]]);
        end
        put24(a);
        put8(m);
        u_qixrp_host.frame(cmd, op, DUM, n);
    endtask
    // enable bits, crossed by a dummy frame
    task automatic set_en(input logic q, input logic c);
        @(posedge sys_clk);
        qe <= q;
        cre <= c;
        @(posedge sys_clk);
        u_qixrp_host.frame(1'b1, 8'h00, 0, 0);
        chk("drive", 8'h00, {7'h00, u_qixrp_host.oe_seen});
    endtask
    task automatic mode_is(input logic e);
        repeat (4) @(posedge sys_clk);
        chk("mode", {7'h00, e}, {7'h00, crm});
    endtask
    task automatic conclude();
        $display("checks %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // each byte read against the oldest note
    always @(u_qixrp_host.got) begin
        chk("read byte", (exp_q.size() > 0) ? exp_q.pop_front() : 8'hxx, u_qixrp_host.rx);
    end

    initial begin
        #1_000_000;
        miscompares++;
        conclude();
    end

    ////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        void'($urandom(30343));
        repeat (2) @(posedge sys_clk);
        rstn <= 1'b1;
        set_en(1'b1, 1'b1);
        put24(24'h00_0000);
        for (int i = 0; i < 64; i++) begin
            mem[i] = 8'($urandom);
            put8(mem[i]);
        end
        u_qixrp_host.frame(1'b1, qixrp_pkg::OP_QUAD_WRITE, 0, 0);
        rd(1'b1, qixrp_pkg::OP_READ_ALIGNED, 24'h00_0013, 8'hFF, 4);
        mode_is(1'b0);
        rd(1'b1, qixrp_pkg::OP_READ_ANY, 24'h00_0010, 8'hA0, 6);
        mode_is(1'b1);
        rd(1'b0, 8'h00, 24'h77_0021, 8'hAF, 3);
        mode_is(1'b1);
        rd(1'b0, 8'h00, 24'h00_0005, 8'h55, 2);
        mode_is(1'b0);
        // every wrap length, then wrapping off
        for (int s = 0; s < 5; s++) begin
            put8((s == 4) ? 8'h40 : 8'(s << 4));
            u_qixrp_host.frame(1'b1, qixrp_pkg::OP_WRAP_SET, 0, 0);
            wsz = (s == 4) ? 0 : 8 << s;
            rd(1'b1, qixrp_pkg::OP_READ_ANY, (s == 4) ? 24'h00_0006 : 24'(wsz - 2), 8'hFF, 4);
        end
        set_en(1'b1, 1'b0);
        rd(1'b1, qixrp_pkg::OP_READ_ANY, 24'h00_0010, 8'hA0, 2);
        mode_is(1'b0);
        set_en(1'b0, 1'b1);
        rd(1'b1, qixrp_pkg::OP_READ_ANY, 24'h00_0010, 8'hA0, 0);
        chk("drive", 8'h00, {7'h00, u_qixrp_host.oe_seen});
        mode_is(1'b0);
        chk("pending", 8'h00, 8'(exp_q.size()));
        conclude();
    end
endmodule

`default_nettype wire

// file: test/qixrp_link_checker.sv
// port assertions of the four-line read path
// assumes a bind into the top module
`timescale 1ns/1ps
`default_nettype none

module qixrp_link_checker #(
    parameter int DUMMY_CYCLES = qixrp_pkg::DUMMY_CLKS
) (
    input wire logic SYS_CLK, // system clock
    input wire logic RSTN, // reset, active low
    input wire logic SCK, // serial clock
    input wire logic CS_N, // select, active low
    input wire logic [3:0] IO_OUT, // driven data
    input wire logic [3:0] IO_OE, // line enables
    input wire logic QUAD_ENABLE_BIT, // quad enable
    input wire logic CONT_READ_ENABLE, // continuous read enable
    input wire logic CONTINUOUS_READ_MODE // mode state
);
    localparam int FIRST = 8 + DUMMY_CYCLES; // earliest data clock
    logic [7:0] cnt; // rises seen in this frame

    ////////////////////////////////////////////////////////////////////////////////
    // rises in the frame
    always_ff @(posedge SCK or posedge CS_N or negedge RSTN) begin
        if (!RSTN || CS_N) begin
            cnt <= 8'h00;
        end else if (cnt != 8'hFF) begin
            cnt <= cnt + 8'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // serial clock domain
    property p_oe_all;
        @(posedge SCK) disable iff (!RSTN) IO_OE == 4'h0 || IO_OE == 4'hF;
    endproperty
    a_oe_all: assert property (p_oe_all) else $error("line enables split");
    property p_data_late;
        @(posedge SCK) disable iff (!RSTN) !CS_N && cnt < 8'(FIRST) |-> IO_OE == 4'h0;
    endproperty
    a_data_late: assert property (p_data_late) else $error("drive too early");
    property p_oe_holds;
        @(posedge SCK) disable iff (!RSTN) IO_OE == 4'hF |=> IO_OE == 4'hF || cnt == 8'h00;
    endproperty
    a_oe_holds: assert property (p_oe_holds) else $error("drive dropped in frame");
    property p_quiet;
        @(posedge SCK) disable iff (!RSTN) IO_OE == 4'h0 |-> IO_OUT == 4'h0;
    endproperty
    a_quiet: assert property (p_quiet) else $error("data while not driving");

    ////////////////////////////////////////////////////////////////////////////////
    // system clock domain
    property p_deselect;
        @(posedge SYS_CLK) disable iff (!RSTN) CS_N && $past(CS_N) |-> IO_OE == 4'h0;
    endproperty
    a_deselect: assert property (p_deselect) else $error("drive while deselected");
    property p_cs_fall;
        @(posedge SYS_CLK) disable iff (!RSTN) $fell(CS_N) |-> (IO_OE == 4'h0) [*4];
    endproperty
    a_cs_fall: assert property (p_cs_fall) else $error("drive at frame start");
    property p_enter;
        @(posedge SYS_CLK) disable iff (!RSTN)
            $rose(CONTINUOUS_READ_MODE) |-> QUAD_ENABLE_BIT && CONT_READ_ENABLE;
    endproperty
    a_enter: assert property (p_enter) else $error("mode without enables");
    property p_keep;
        @(posedge SYS_CLK) disable iff (!RSTN)
            (CS_N && QUAD_ENABLE_BIT && CONT_READ_ENABLE) [*4] |-> $stable(CONTINUOUS_READ_MODE);
    endproperty
    a_keep: assert property (p_keep) else $error("mode moved while idle");

    // main scenarios reached
    c_mode: cover property (@(posedge SYS_CLK) disable iff (!RSTN) $rose(CONTINUOUS_READ_MODE));
    c_fast: cover property (@(posedge SCK) disable iff (!RSTN) IO_OE == 4'hF && cnt == 8'(FIRST));
    c_cut: cover property (@(posedge SYS_CLK) disable iff (!RSTN)
        $rose(CS_N) && $past(IO_OE) == 4'hF);
endmodule

bind qixrp_link qixrp_link_checker #(.DUMMY_CYCLES(DUMMY_CYCLES)) u_qixrp_link_checker (
    .SYS_CLK(SYS_CLK), .RSTN(RSTN), .SCK(SCK), .CS_N(CS_N), .IO_OUT(IO_OUT), .IO_OE(IO_OE),
    .QUAD_ENABLE_BIT(QUAD_ENABLE_BIT), .CONT_READ_ENABLE(CONT_READ_ENABLE),
    .CONTINUOUS_READ_MODE(CONTINUOUS_READ_MODE)
);

`default_nettype wire
